//--- hdl/wws_defs.svh
// Timing constants of the window watchdog supervisor core.
// Assumes a single 25 MHz clock; all timing derives from it.
//
// Overview of operation
// [R1] Reset low while supply outside window.
// [R2] Hold reset after return, within twenty percent.
// [R3] Host kicks between fast and slow limit.
// [R4] Bad kick spacing raises watchdog fault.
// [R5] Fault pulse 50 ms early, 100 ms late.
// [R6] Overvoltage latches flag low after 5 us.
// [R7] Only a clear low releases the flag.
// [R8] Clear must stay low 0.4 us.
// [R9] Clear works only without overvoltage, reset high.
// [R10] Clear low beyond 5 us forces reset.
// [R11] Host kicks last 24 us after fault.
// [R12] Timeouts accurate twenty percent plus sync error.
// [R13] Interval counter zeroed by kick and reset release.
// [R14] Clear ignored during overvoltage.
// [R15] Slow limit ten times fast, powers of two.
// [R16] Kick and clear synchronised before use.
// [R17] Periods fixed by build-time parameters.
`ifndef WWS_DEFS_SVH
`define WWS_DEFS_SVH

`define WWS_CLOCK_MHZ 25
`define WWS_US_PER_MS 1000
`define WWS_NS_PER_US 1000

// One watchdog tick is one microsecond.
`define WWS_TICK_US 1
`define WWS_TICK_CYCLES (`WWS_TICK_US * `WWS_CLOCK_MHZ)

// Fast limit is two to this power, in milliseconds.
`define WWS_FAST_EXP 0
`define WWS_FAST_EXP_MAX 12
`define WWS_SLOW_FACTOR 10

`define WWS_EARLY_PULSE_MS 50
`define WWS_LATE_PULSE_MS 100
`define WWS_RESET_HOLD_MS 1

`define WWS_SURGE_DELAY_US 5
`define WWS_SURGE_DELAY_CYCLES (`WWS_SURGE_DELAY_US * `WWS_CLOCK_MHZ)

// Least time, rounded up to whole cycles.
`define WWS_CLR_MIN_NS 400
`define WWS_CLR_MIN_CYCLES \
  ((`WWS_CLR_MIN_NS * `WWS_CLOCK_MHZ + `WWS_NS_PER_US - 1) / `WWS_NS_PER_US)

`define WWS_CLR_LONG_US 5
`define WWS_CLR_LONG_CYCLES (`WWS_CLR_LONG_US * `WWS_CLOCK_MHZ)

`define WWS_SYNC_IDLE 1'b1

`endif

//--- hdl/wws_pkg.sv
// Types shared by the window watchdog supervisor core.
// Assumes nothing beyond a SystemVerilog compiler.
package wws_pkg;

  typedef enum {
    WD_IDLE,
    WD_WATCH,
    WD_EARLY,
    WD_LATE
  } wws_wd_state_e;

endpackage

//--- hdl/wws_input_sync.sv
// Two-stage synchroniser with falling-edge detect for one host pin.
// Assumes the pin idles high; edges are seen two to three clocks late.
`include "wws_defs.svh"

module wws_input_sync (
  input  wire logic clock,
  input  wire logic resetn,
  input  wire logic asyncIn,
  output logic      syncOut,
  output logic      fallPulse
);

  logic stage1_reg;
  logic stage2_reg;
  logic prev_reg;
  logic stage1_next;
  logic stage2_next;
  logic prev_next;

  always_comb
  begin
    stage1_next = asyncIn;
    stage2_next = stage1_reg;
    prev_next   = stage2_reg;
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      stage1_reg <= `WWS_SYNC_IDLE;
      stage2_reg <= `WWS_SYNC_IDLE;
      prev_reg   <= `WWS_SYNC_IDLE;
    end
    else
    begin
      stage1_reg <= stage1_next;
      stage2_reg <= stage2_next;
      prev_reg   <= prev_next;
    end
  end

  // Only the second and third stages are looked at, so a metastable first stage never spreads.
  assign syncOut   = stage2_reg;
  assign fallPulse = prev_reg & ~stage2_reg;

endmodule

//--- hdl/wws_supervisor.sv
// Digital core of a supply supervisor: window watchdog, overvoltage latch, reset timer.
// Assumes comparator inputs are synchronous to clock; kick and clear come from a host.
`include "wws_defs.svh"

module wws_supervisor #(
  parameter int TICK_CYCLES       = `WWS_TICK_CYCLES,
  parameter int FAST_EXP          = `WWS_FAST_EXP,
  parameter int EARLY_PULSE_TICKS = `WWS_EARLY_PULSE_MS * `WWS_US_PER_MS,
  parameter int LATE_PULSE_TICKS  = `WWS_LATE_PULSE_MS * `WWS_US_PER_MS,
  parameter int RESET_HOLD_TICKS  = `WWS_RESET_HOLD_MS * `WWS_US_PER_MS,
  parameter int CNT_W             = 27
) (
  input  wire logic clock,
  input  wire logic resetn,
  input  wire logic underVoltageIn,
  input  wire logic overVoltageIn,
  input  wire logic watchdogKickIn,
  input  wire logic faultClearInN,
  output logic      resetOutN,
  output logic      watchdogFaultOutN,
  output logic      overvoltageFlagOutN
);

  // Periods are fixed at build time; nothing changes them while running. [R17]
  localparam int FAST_EXP_USED = (FAST_EXP > `WWS_FAST_EXP_MAX) ? `WWS_FAST_EXP_MAX : FAST_EXP;
  localparam logic [CNT_W-1:0] FAST_TICKS =
    CNT_W'((1 << FAST_EXP_USED) * `WWS_US_PER_MS); // [R15]
  localparam logic [CNT_W-1:0] SLOW_TICKS =
    CNT_W'(`WWS_SLOW_FACTOR * (1 << FAST_EXP_USED) * `WWS_US_PER_MS); // [R15]
  localparam logic [CNT_W-1:0] EARLY_LAST = CNT_W'(EARLY_PULSE_TICKS - 1);
  localparam logic [CNT_W-1:0] LATE_LAST  = CNT_W'(LATE_PULSE_TICKS - 1);
  localparam logic [CNT_W-1:0] HOLD_LAST  = CNT_W'(RESET_HOLD_TICKS - 1);
  localparam logic [7:0]       TICK_LAST  = 8'(TICK_CYCLES - 1);
  localparam logic [7:0]       SURGE_LAST = 8'(`WWS_SURGE_DELAY_CYCLES - 1);
  localparam logic [7:0]       CLR_MIN_LAST = 8'(`WWS_CLR_MIN_CYCLES - 1);
  localparam logic [7:0]       CLR_LONG   = 8'(`WWS_CLR_LONG_CYCLES);
  localparam logic [7:0]       CNT8_MAX   = 8'hff;

  // Kick and clear pass through synchronisers before any edge or width logic. [R16]
  logic [1:0] pinRaw;
  logic [1:0] pinSync;
  logic [1:0] pinFall;
  assign pinRaw = {faultClearInN, watchdogKickIn};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_sync
      wws_input_sync u_wws_input_sync (
        .clock     (clock),
        .resetn    (resetn),
        .asyncIn   (pinRaw[gi]),
        .syncOut   (pinSync[gi]),
        .fallPulse (pinFall[gi])
      );
    end
  endgenerate

  logic kickFall;
  logic clearLow;
  assign kickFall = pinFall[0];
  assign clearLow = ~pinSync[1];

  logic                  tick;
  logic [7:0]            tickCount_reg;
  logic [7:0]            tickCount_next;
  logic [7:0]            surgeCount_reg;
  logic [7:0]            surgeCount_next;
  logic [7:0]            clearCount_reg;
  logic [7:0]            clearCount_next;
  logic                  flagN_reg;
  logic                  flagN_next;
  logic [CNT_W-1:0]      holdCount_reg;
  logic [CNT_W-1:0]      holdCount_next;
  logic                  resetN_reg;
  logic                  resetN_next;
  wws_pkg::wws_wd_state_e wdState_reg;
  wws_pkg::wws_wd_state_e wdState_next;
  logic [CNT_W-1:0]      interval_reg;
  logic [CNT_W-1:0]      interval_next;
  logic [CNT_W-1:0]      pulseCount_reg;
  logic [CNT_W-1:0]      pulseCount_next;
  logic                  faultN_reg;
  logic                  faultN_next;
  logic                  clearValid;
  logic                  clearLong;

  // A one-microsecond enable paces every long period; its phase adds up to one tick of error,
  // far inside the allowed tolerance. [R12]
  assign tick = (tickCount_reg == TICK_LAST);

  // The clear pin only counts while no overvoltage is present. [R14]
  assign clearValid = clearLow && !overVoltageIn && (clearCount_reg == CLR_MIN_LAST); // [R8]
  assign clearLong  = clearLow && !overVoltageIn && (clearCount_reg == CLR_LONG); // [R10]

  always_comb
  begin
    tickCount_next  = tick ? 8'h00 : tickCount_reg + 8'h01;
    surgeCount_next = surgeCount_reg;
    clearCount_next = clearCount_reg;
    flagN_next      = flagN_reg;
    if (!overVoltageIn)
      surgeCount_next = 8'h00;
    else if (surgeCount_reg != SURGE_LAST)
      surgeCount_next = surgeCount_reg + 8'h01;
    if (overVoltageIn || !clearLow)
      clearCount_next = 8'h00; // [R14]
    else if (clearCount_reg != CNT8_MAX)
      clearCount_next = clearCount_reg + 8'h01;
    // Setting wins over a clear arriving in the same cycle.
    if (overVoltageIn && surgeCount_reg == SURGE_LAST)
      flagN_next = 1'b0; // [R6]
    else if (clearValid && resetN_reg)
      flagN_next = 1'b1; // [R7] [R9]
  end

  always_comb
  begin
    holdCount_next = holdCount_reg;
    resetN_next    = resetN_reg;
    if (underVoltageIn || overVoltageIn || clearLong)
    begin
      holdCount_next = '0; // [R1] [R10]
      resetN_next    = 1'b0;
    end
    else if (!resetN_reg && tick)
    begin
      if (holdCount_reg == HOLD_LAST)
        resetN_next = 1'b1; // [R2]
      else
        holdCount_next = holdCount_reg + CNT_W'(1);
    end
  end

  always_comb
  begin
    wdState_next    = wdState_reg;
    interval_next   = interval_reg;
    pulseCount_next = pulseCount_reg;
    faultN_next     = faultN_reg;
    if (!resetN_reg)
    begin
      // Held idle at zero, so the release of reset starts a fresh interval. [R13]
      wdState_next  = wws_pkg::WD_IDLE;
      interval_next = '0;
      faultN_next   = 1'b1;
    end
    else
    begin
      case (wdState_reg)
        wws_pkg::WD_IDLE:
        begin
          wdState_next  = wws_pkg::WD_WATCH;
          interval_next = '0; // [R13]
        end
        wws_pkg::WD_WATCH:
        begin
          if (kickFall)
          begin
            interval_next = '0; // [R13]
            if (interval_reg < FAST_TICKS)
            begin
              wdState_next    = wws_pkg::WD_EARLY; // [R4]
              pulseCount_next = '0;
              faultN_next     = 1'b0;
            end
          end
          else if (tick)
          begin
            if (interval_reg == SLOW_TICKS - CNT_W'(1))
            begin
              wdState_next    = wws_pkg::WD_LATE; // [R4]
              pulseCount_next = '0;
              faultN_next     = 1'b0;
            end
            else
              interval_next = interval_reg + CNT_W'(1);
          end
        end
        wws_pkg::WD_EARLY,
        wws_pkg::WD_LATE:
        begin
          // Kicks during the pulse are not judged; the pulse end opens a new interval.
          if (tick)
          begin
            if (pulseCount_reg == ((wdState_reg == wws_pkg::WD_EARLY) ? EARLY_LAST : LATE_LAST))
            begin
              wdState_next  = wws_pkg::WD_WATCH; // [R5]
              interval_next = '0;
              faultN_next   = 1'b1;
            end
            else
              pulseCount_next = pulseCount_reg + CNT_W'(1);
          end
        end
        default:
        begin
          wdState_next = wws_pkg::WD_IDLE;
          faultN_next  = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      tickCount_reg  <= 8'h00;
      surgeCount_reg <= 8'h00;
      clearCount_reg <= 8'h00;
      flagN_reg      <= 1'b1;
      holdCount_reg  <= '0;
      resetN_reg     <= 1'b0;
      wdState_reg    <= wws_pkg::WD_IDLE;
      interval_reg   <= '0;
      pulseCount_reg <= '0;
      faultN_reg     <= 1'b1;
    end
    else
    begin
      tickCount_reg  <= tickCount_next;
      surgeCount_reg <= surgeCount_next;
      clearCount_reg <= clearCount_next;
      flagN_reg      <= flagN_next;
      holdCount_reg  <= holdCount_next;
      resetN_reg     <= resetN_next;
      wdState_reg    <= wdState_next;
      interval_reg   <= interval_next;
      pulseCount_reg <= pulseCount_next;
      faultN_reg     <= faultN_next;
    end
  end

  assign resetOutN           = resetN_reg;
  assign watchdogFaultOutN   = faultN_reg;
  assign overvoltageFlagOutN = flagN_reg;

  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);

  a_window_reset: assert property ((underVoltageIn || overVoltageIn) |=> !resetOutN) // [R1]
    else $error("reset not low while supply outside window");
  a_hold_before_release: assert property ($rose(resetOutN) |-> // [R2]
      ($past(holdCount_reg) == HOLD_LAST) && $past(tick))
    else $error("reset released before hold period");
  a_early_kick_fault: assert property ((wdState_reg == wws_pkg::WD_WATCH && kickFall && // [R4]
      interval_reg < FAST_TICKS) |=> !watchdogFaultOutN && wdState_reg == wws_pkg::WD_EARLY)
    else $error("early kick did not raise fault");
  a_pulse_length: assert property ($rose(watchdogFaultOutN) && $past(resetOutN) |-> // [R5]
      $past(pulseCount_reg) == (($past(wdState_reg) == wws_pkg::WD_EARLY) ? EARLY_LAST
      : LATE_LAST))
    else $error("fault pulse length wrong");
  a_surge_flag_delay: assert property ($fell(overvoltageFlagOutN) |-> // [R6]
      $past(surgeCount_reg) == SURGE_LAST && $past(overVoltageIn))
    else $error("flag set without full delay");
  a_flag_clear_cause: assert property ($rose(overvoltageFlagOutN) |-> // [R7] [R8]
      $past(clearLow) && $past(clearCount_reg) == CLR_MIN_LAST)
    else $error("flag released without valid clear");
  a_clear_conditions: assert property ($rose(overvoltageFlagOutN) |-> // [R9]
      !$past(overVoltageIn) && $past(resetOutN))
    else $error("flag released under fault or reset");
  a_long_clear_reset: assert property (clearLong |=> !resetOutN [*2]) // [R10]
    else $error("long clear did not force reset");
  a_interval_zero: assert property ((wdState_reg == wws_pkg::WD_WATCH && kickFall) or // [R13]
      $rose(resetOutN) |=> interval_reg == '0)
    else $error("interval counter not zeroed");
  a_clear_ignored: assert property (overVoltageIn |=> clearCount_reg == 8'h00) // [R14]
    else $error("clear counted during overvoltage");

  c_early_fault: cover property ($fell(watchdogFaultOutN) && wdState_reg == wws_pkg::WD_EARLY);
  c_late_fault: cover property ($fell(watchdogFaultOutN) && wdState_reg == wws_pkg::WD_LATE);
  c_flag_cleared: cover property ($rose(overvoltageFlagOutN));
  c_long_clear: cover property (clearLong ##1 !resetOutN);

endmodule

//--- tb/wws_host_model.sv
// Behavioural host processor on the kick and clear pins of the supervisor.
// Assumes the bench calls its tasks one at a time; both pins idle high.
module wws_host_model #(
  parameter int KICK_LOW_CYCLES = 600,
  parameter int LONG_CYCLES     = 125,
  parameter int HOLD_CYCLES     = 30
) (
  input  wire logic clock,
  output logic      kickOut,
  output logic      clearOutN
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    kickOut   = 1'b1;
    clearOutN = 1'b1;
  end

  // One falling edge per call; the caller sets the spacing of the calls.
  // The low phase is 24 us at 25 MHz so a kick is still seen after a fault.
  task automatic kick();
    @(negedge clock);
    kickOut = 1'b0;
    repeat (KICK_LOW_CYCLES) @(negedge clock);
    kickOut = 1'b1;
  endtask

  // Valid clears are at least 10 cycles; shorter ones only when commanded.
  // A long low is followed by a high gap above the hold period.
  task automatic clear(input int lowCycles);
    @(negedge clock);
    clearOutN = 1'b0;
    repeat (lowCycles) @(negedge clock);
    clearOutN = 1'b1;
    if (lowCycles > LONG_CYCLES)
      repeat (HOLD_CYCLES + 10) @(negedge clock);
  endtask
endmodule

//--- tb/window_watchdog_supervisor_bench.sv
// Self-checking bench of the supervisor core with a host model on kick and clear.
// Assumes shortened counts: one tick per clock, fast limit 1000, slow limit 10000.
module window_watchdog_supervisor_bench;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int HOLD  = 30;
  localparam int EARLY = 20;
  localparam int LATE  = 40;
  localparam int SLOW  = 10000;

  logic clock;
  logic resetn;
  logic underVoltageIn;
  logic overVoltageIn;
  logic watchdogKickIn;
  logic faultClearInN;
  logic resetOutN;
  logic watchdogFaultOutN;
  logic overvoltageFlagOutN;
  int   errCount    = 0;
  int   cmpCount    = 0;
  int   faultLowCnt = 0;

  wws_supervisor #(
    .TICK_CYCLES       (1),
    .EARLY_PULSE_TICKS (EARLY),
    .LATE_PULSE_TICKS  (LATE),
    .RESET_HOLD_TICKS  (HOLD)
  ) u_wws_supervisor (
    .clock               (clock),
    .resetn              (resetn),
    .underVoltageIn      (underVoltageIn),
    .overVoltageIn       (overVoltageIn),
    .watchdogKickIn      (watchdogKickIn),
    .faultClearInN       (faultClearInN),
    .resetOutN           (resetOutN),
    .watchdogFaultOutN   (watchdogFaultOutN),
    .overvoltageFlagOutN (overvoltageFlagOutN)
  );

  wws_host_model u_wws_host_model (
    .clock     (clock),
    .kickOut   (watchdogKickIn),
    .clearOutN (faultClearInN)
  );

  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  always @(posedge clock)
    if (watchdogFaultOutN === 1'b0)
      faultLowCnt++;

  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic chk(input string what, input logic seen, input logic exp);
    cmpCount++;
    if (seen !== exp)
    begin
      errCount++;
      $display("[FAIL] %s expected %b seen %b", what, exp, seen);
    end
  endtask

  task automatic waitRst(input int lim, output int n);
    n = 0;
    while (resetOutN !== 1'b1 && n < lim)
    begin
      cyc(1);
      n++;
    end
  endtask

  // Waits for a fault pulse, then measures its low time in cycles.
  task automatic faultPulse(input int lim, output int at, output int len);
    at = 0;
    len = 0;
    while (watchdogFaultOutN !== 1'b0 && at < lim)
    begin
      cyc(1);
      at++;
    end
    while (watchdogFaultOutN === 1'b0 && len < 200)
    begin
      cyc(1);
      len++;
    end
  endtask

  task automatic stopTest();
    $display("counts: %0d compares, %0d mismatches", cmpCount, errCount);
    if (errCount == 0 && cmpCount > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic testPowerOn();
    int n;
    cyc(10);
    chk("rst in reset", resetOutN, 1'b0);
    chk("wdo in reset", watchdogFaultOutN, 1'b1);
    chk("flag in reset", overvoltageFlagOutN, 1'b1);
    cyc(2);
    resetn = 1'b1;
    waitRst(40, n);
    chk("power-on hold", logic'(n >= HOLD - 2 && n < 40), 1'b1);
    $display("test power-on done");
  endtask

  task automatic testUnderVoltage();
    int n;
    underVoltageIn = 1'b1;
    cyc(1);
    chk("rst on uv", resetOutN, 1'b0);
    cyc(20);
    underVoltageIn = 1'b0;
    cyc(HOLD - 2);
    chk("rst hold", resetOutN, 1'b0);
    waitRst(6, n);
    chk("rst release", resetOutN, 1'b1);
    $display("test undervoltage done");
  endtask

  // The interval counts from reset release, so a kick 100 cycles later is early.
  task automatic testEarlyKick();
    int at;
    int len;
    cyc(100);
    fork
      u_wws_host_model.kick();
      faultPulse(10, at, len);
    join
    chk("early fault", logic'(at < 10), 1'b1);
    chk("early width", logic'(len >= EARLY - 1 && len <= EARLY + 1), 1'b1);
    $display("test early kick done");
  endtask

  task automatic testGoodKicks();
    int base;
    base = faultLowCnt;
    repeat (3)
    begin
      cyc(1399);
      u_wws_host_model.kick();
    end
    chk("no fault in window", logic'(faultLowCnt == base), 1'b1);
    $display("test good kicks done");
  endtask

  task automatic testLateKick();
    int base;
    int at;
    int len;
    base = faultLowCnt;
    cyc(SLOW - 620);
    chk("no fault before slow", logic'(faultLowCnt == base), 1'b1);
    faultPulse(60, at, len);
    chk("late fault", logic'(at < 60), 1'b1);
    chk("late width", logic'(len >= LATE - 1 && len <= LATE + 1), 1'b1);
    $display("test late kick done");
  endtask

  task automatic testOverVoltage();
    int n;
    overVoltageIn = 1'b1;
    cyc(1);
    chk("rst on surge", resetOutN, 1'b0);
    cyc(99);
    overVoltageIn = 1'b0;
    cyc(2);
    chk("flag short", overvoltageFlagOutN, 1'b1);
    waitRst(40, n);
    overVoltageIn = 1'b1;
    cyc(120);
    chk("flag delay", overvoltageFlagOutN, 1'b1);
    u_wws_host_model.clear(20);
    chk("flag latch", overvoltageFlagOutN, 1'b0);
    overVoltageIn = 1'b0;
    cyc(2);
    u_wws_host_model.clear(20);
    chk("clear in reset", overvoltageFlagOutN, 1'b0);
    waitRst(40, n);
    chk("rst after surge", resetOutN, 1'b1);
    u_wws_host_model.clear(5);
    cyc(5);
    chk("short clear", overvoltageFlagOutN, 1'b0);
    u_wws_host_model.clear(20);
    chk("valid clear", overvoltageFlagOutN, 1'b1);
    $display("test overvoltage done");
  endtask

  task automatic testLongClear();
    int n;
    fork
      u_wws_host_model.clear(200);
      begin
        cyc(110);
        chk("rst before long", resetOutN, 1'b1);
        cyc(30);
        chk("rst on long", resetOutN, 1'b0);
      end
    join
    waitRst(20, n);
    chk("rst after long", resetOutN, 1'b1);
    $display("test long clear done");
  endtask

  initial
  begin
    resetn         = 1'b0;
    underVoltageIn = 1'b0;
    overVoltageIn  = 1'b0;
    testPowerOn();
    testUnderVoltage();
    testEarlyKick();
    testGoodKicks();
    testLateKick();
    testOverVoltage();
    testLongClear();
    stopTest();
  end

  // The tests need about 17000 cycles; this limit leaves ample margin.
  initial
  begin
    repeat (40000) @(posedge clock);
    errCount++;
    $display("[FAIL] run time expected finish seen hang");
    stopTest();
  end
endmodule
